/* File: rtl/wtc_top.sv */
`timescale 1ns/100ps
//
// Functional notes
// RULE1 - Clearing enable only takes effect while change-enable is already set.
// RULE2 - Change-enable bit clears itself four clock cycles after being written one.
// RULE3 - Timeout select changes need change-enable set beforehand.
// RULE4 - Enable bit three written one turns the watchdog on; zero turns off.
// RULE5 - Disable: write change-enable and enable together, then enable zero within four.
// RULE6 - Safety level two refuses every disable, even a timed one.
// RULE7 - Watchdog reset flag forces enable on; clear flag before enable.
// RULE8 - Watchdog control bits seven to five read as zero.
// RULE9 - Software should clear reset flag and enable during initialisation.
// RULE10 - Software should restart the watchdog before changing timeout select.
// RULE11 - Timeout select codes give ticks every 1K to 512K slow cycles.
// RULE12 - Timeout equals eight watchdog ticks.
// RULE13 - Sense select picks sense tick and motion mode; 110 gives 32.
// RULE14 - Timeout select write without change-enable is ignored.
// RULE15 - Three-bit tick counter resets system on overflow; restart clears it.
// RULE16 - Prescaler restart works only while disabled; bit self-clears after four cycles.
// RULE17 - Interval select codes give ticks every 8 to 1024K slow cycles.
// RULE18 - Safety fuse selects level; level two starts enabled, never disables.
module wtc_top #(
  parameter int PRE_W = wtc_pkg::PRE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [wtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Slow oscillator and core
  input wire logic scl_tick,
  input wire logic watchdog_restart_instr,
  input wire logic safety_fuse,
  // Outputs to the system
  output logic wdt_reset_req,
  output logic wdt_active,
  output logic interval_tick,
  output logic sense_tick,
  output logic motion_sense_on,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////

  if (PRE_W < wtc_pkg::PRE_W) begin : g_bad_pre
    $error("wtc_top: PRE_W too small for the longest tap");
  end

  wtc_pre_if #(.W(PRE_W)) pre ();

  wtc_prescaler #(.W(PRE_W)) u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .pre(pre)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_wd;
  logic wr_t0;
  logic wr_st;
  logic wr_mask;
  logic wr_cause;

  assign wr_wd = reg_wr && (reg_addr == wtc_pkg::OFS_WDCTL);
  assign wr_t0 = reg_wr && (reg_addr == wtc_pkg::OFS_T0CTL);
  assign wr_st = reg_wr && (reg_addr == wtc_pkg::OFS_IRQ_ST);
  assign wr_mask = reg_wr && (reg_addr == wtc_pkg::OFS_IRQ_MASK);
  assign wr_cause = reg_wr && (reg_addr == wtc_pkg::OFS_CAUSE);

  //////////////////////////////////////////////////////////////////////////////
  // Safety level, caught once after reset release

  logic init_r;
  logic lvl2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= 1'b0;
      lvl2_r <= 1'b0;
    end else if (!init_r) begin
      init_r <= 1'b1;
      lvl2_r <= safety_fuse; // RULE18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change-enable window

  logic ce_r;
  logic [2:0] ce_cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (wr_wd && reg_wdata[wtc_pkg::WD_CE_BIT]) begin
      ce_r <= 1'b1;
      ce_cnt_r <= 3'(wtc_pkg::CE_HOLD - 1); // RULE2
    end else if (ce_r) begin
      if (ce_cnt_r == 3'h0) begin
        ce_r <= 1'b0; // RULE2
      end else begin
        ce_cnt_r <= ce_cnt_r - 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable bit

  logic wde_r;
  logic watchdog_reset_flag_r;
  logic wdt_on;

  // Level two and the reset flag hold the watchdog on regardless of the stored bit
  assign wdt_on = wde_r | watchdog_reset_flag_r | lvl2_r; // RULE7 RULE6

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wde_r <= wtc_pkg::WDCTL_RST[wtc_pkg::WD_EN_BIT];
    end else if (!init_r && safety_fuse) begin
      wde_r <= 1'b1; // RULE18
    end else if (watchdog_reset_flag_r) begin
      wde_r <= 1'b1; // RULE7
    end else if (wr_wd) begin
      if (reg_wdata[wtc_pkg::WD_EN_BIT]) begin
        wde_r <= 1'b1; // RULE4
      end else if (ce_r && !lvl2_r) begin
        wde_r <= 1'b0; // RULE1 RULE5 RULE6
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timeout select

  logic [2:0] wd_ps_r;

  // A rejected write keeps the old period, so a stray store cannot shorten it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_ps_r <= wtc_pkg::WDCTL_RST[wtc_pkg::WD_PS_LSB +: 3];
    end else if (wr_wd && ce_r) begin
      wd_ps_r <= reg_wdata[wtc_pkg::WD_PS_LSB +: 3]; // RULE3 RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interval timer control

  logic [2:0] pbs_r;
  logic [2:0] pas_r;
  logic ie_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbs_r <= wtc_pkg::T0CTL_RST[wtc_pkg::T0_PBS_LSB +: 3];
      pas_r <= wtc_pkg::T0CTL_RST[wtc_pkg::T0_PAS_LSB +: 3];
      ie_r <= wtc_pkg::T0CTL_RST[wtc_pkg::T0_IE_BIT];
    end else if (wr_t0) begin
      pbs_r <= reg_wdata[wtc_pkg::T0_PBS_LSB +: 3];
      pas_r <= reg_wdata[wtc_pkg::T0_PAS_LSB +: 3];
      ie_r <= reg_wdata[wtc_pkg::T0_IE_BIT];
    end
  end

  // Prescaler restart; refused while the watchdog runs so it cannot be starved
  logic pr_start;
  logic pr_r;
  logic [2:0] pr_cnt_r;

  assign pr_start = wr_t0 && reg_wdata[wtc_pkg::T0_PR_BIT] && !wdt_on; // RULE16

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pr_r <= wtc_pkg::T0CTL_RST[wtc_pkg::T0_PR_BIT];
      pr_cnt_r <= 3'h0;
    end else if (pr_start) begin
      pr_r <= 1'b1;
      pr_cnt_r <= 3'(wtc_pkg::PR_HOLD - 1);
    end else if (pr_r) begin
      if (pr_cnt_r == 3'h0) begin
        pr_r <= 1'b0; // RULE16
      end else begin
        pr_cnt_r <= pr_cnt_r - 3'h1;
      end
    end
  end

  assign pre.scl_tick = scl_tick;
  assign pre.restart = pr_start;

  //////////////////////////////////////////////////////////////////////////////
  // Tap selection

  logic [4:0] wd_exp;
  logic [4:0] int_exp;
  logic [4:0] sen_exp;
  logic wd_tick;

  assign wd_exp = wtc_pkg::WD_EXP[wd_ps_r*5 +: 5]; // RULE11
  assign int_exp = wtc_pkg::INT_EXP[pas_r*5 +: 5]; // RULE17
  assign sen_exp = wtc_pkg::SEN_EXP[pbs_r*5 +: 5]; // RULE13
  assign wd_tick = wdt_on && pre.taps[wd_exp]; // RULE11

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog tick counter

  logic [2:0] wd_cnt_r;
  logic ovf_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_r <= 3'h0;
      ovf_r <= 1'b0;
    end else if (!wdt_on || watchdog_restart_instr) begin
      wd_cnt_r <= 3'h0; // RULE15
      ovf_r <= 1'b0;
    end else if (wd_tick) begin
      if (wd_cnt_r == wtc_pkg::WD_LAST) begin
        wd_cnt_r <= 3'h0;
        ovf_r <= 1'b1; // RULE12 RULE15
      end else begin
        wd_cnt_r <= wd_cnt_r + 3'h1;
        ovf_r <= 1'b0;
      end
    end else begin
      ovf_r <= 1'b0;
    end
  end

  // Reset flag survives the system reset it causes; only rst_n or a write of zero to the reset-cause bit clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (ovf_r) begin
      watchdog_reset_flag_r <= 1'b1;
    end else if (wr_cause && !reg_wdata[wtc_pkg::CAUSE_WATCHDOG_RESET_FLAG_BIT]) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tick outputs

  logic int_tick_r;
  logic sen_tick_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_tick_r <= 1'b0;
      sen_tick_r <= 1'b0;
    end else begin
      int_tick_r <= pre.taps[int_exp];
      sen_tick_r <= wtc_pkg::SEN_RUN[pbs_r] && pre.taps[sen_exp]; // RULE13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [wtc_pkg::IRQ_W-1:0] st_r;
  logic [wtc_pkg::IRQ_W-1:0] mask_r;
  logic [wtc_pkg::IRQ_W-1:0] ev;
  logic [wtc_pkg::IRQ_W-1:0] clr;
  logic [wtc_pkg::IRQ_W-1:0] gate;

  always_comb begin
    ev = '0;
    ev[wtc_pkg::IRQ_INTERVAL_BIT] = int_tick_r;
    ev[wtc_pkg::IRQ_WDT_BIT] = ovf_r;
    ev[wtc_pkg::IRQ_SENSE_BIT] = sen_tick_r;
    gate = mask_r;
    gate[wtc_pkg::IRQ_INTERVAL_BIT] = mask_r[wtc_pkg::IRQ_INTERVAL_BIT] & ie_r;
  end

  assign clr = wr_st ? reg_wdata[wtc_pkg::IRQ_W-1:0] : '0;

  // A new event in the clearing cycle stays pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= (st_r & ~clr) | ev;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= wtc_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[wtc_pkg::IRQ_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read back

  logic [7:0] rdata_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        wtc_pkg::OFS_WDCTL: begin
          rdata_r <= {3'h0, ce_r, wdt_on, wd_ps_r}; // RULE8
        end
        wtc_pkg::OFS_T0CTL: begin
          rdata_r <= {pbs_r, pr_r, ie_r, pas_r};
        end
        wtc_pkg::OFS_IRQ_ST: begin
          rdata_r <= {5'h00, st_r};
        end
        wtc_pkg::OFS_IRQ_MASK: begin
          rdata_r <= {5'h00, mask_r};
        end
        wtc_pkg::OFS_CAUSE: begin
          rdata_r <= {7'h00, watchdog_reset_flag_r};
        end
        default: begin
          rdata_r <= 8'h00;
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = rdata_r;
  assign wdt_reset_req = ovf_r;
  assign wdt_active = wdt_on;
  assign interval_tick = int_tick_r;
  assign sense_tick = sen_tick_r;
  assign motion_sense_on = wtc_pkg::SEN_RUN[pbs_r];
  assign irq = |(st_r & gate);

endmodule

/* File: rtl/wtc_pkg.sv */
package wtc_pkg;

  // Register map, byte index on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_WDCTL = 3'h0;
  localparam logic [2:0] OFS_T0CTL = 3'h1;
  localparam logic [2:0] OFS_IRQ_ST = 3'h2;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h3;
  localparam logic [2:0] OFS_CAUSE = 3'h4;

  // Watchdog control fields
  localparam int WD_CE_BIT = 4;
  localparam int WD_EN_BIT = 3;
  localparam int WD_PS_LSB = 0;

  // Interval timer control fields
  localparam int T0_PBS_LSB = 5;
  localparam int T0_PR_BIT = 4;
  localparam int T0_IE_BIT = 3;
  localparam int T0_PAS_LSB = 0;

  // Reset-cause and interrupt status fields
  localparam int CAUSE_WATCHDOG_RESET_FLAG_BIT = 0;
  localparam int IRQ_INTERVAL_BIT = 0;
  localparam int IRQ_WDT_BIT = 1;
  localparam int IRQ_SENSE_BIT = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [7:0] WDCTL_RST = 8'h00;
  localparam logic [7:0] T0CTL_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Timing counts; the holds in clk cycles, WD_LAST in watchdog ticks
  localparam int CE_HOLD = 4;
  localparam int PR_HOLD = 4;
  localparam logic [2:0] WD_LAST = 3'h7;

  // Slow-oscillator divider stages; tap k pulses every 2**k slow cycles
  localparam int PRE_W = 20;

  // Tap exponents, code 7 in the top slice
  localparam logic [39:0] WD_EXP = {5'h13, 5'h12, 5'h10, 5'h0f, 5'h0d, 5'h0c, 5'h0b, 5'h0a};
  localparam logic [39:0] INT_EXP = {5'h14, 5'h12, 5'h0f, 5'h0c, 5'h0a, 5'h07, 5'h05, 5'h03};
  localparam logic [39:0] SEN_EXP = {5'h00, 5'h05, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h00};
  localparam logic [7:0] SEN_RUN = 8'h7e;

endpackage

/* File: rtl/wtc_pre_if.sv */
`timescale 1ns/100ps
interface wtc_pre_if #(
  parameter int W = 20
);
  logic scl_tick;
  logic restart;
  logic [W:0] taps;

  modport div (
    input scl_tick,
    input restart,
    output taps
  );

  modport ctl (
    output scl_tick,
    output restart,
    input taps
  );
endinterface

/* File: rtl/wtc_prescaler.sv */
`timescale 1ns/100ps
module wtc_prescaler #(
  parameter int W = wtc_pkg::PRE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider link
  wtc_pre_if.div pre
);

  logic [W-1:0] cnt_r;
  logic [W:0] taps_r;

  if (W < 1) begin : g_bad_w
    $error("wtc_prescaler: W must be at least 1");
  end

  // Free-running from power-on; restart drops the phase to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (pre.restart) begin
      cnt_r <= '0;
    end else if (pre.scl_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taps_r[0] <= 1'b0;
    end else begin
      taps_r[0] <= pre.scl_tick & ~pre.restart;
    end
  end

  // Tap k fires on the slow tick that completes 2**k cycles
  for (genvar k = 1; k <= W; k++) begin : g_tap
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        taps_r[k] <= 1'b0;
      end else begin
        taps_r[k] <= pre.scl_tick & ~pre.restart & (&cnt_r[k-1:0]);
      end
    end
  end

  assign pre.taps = taps_r;

endmodule

/* File: verif/wtc_top_checker.sv */
`timescale 1ns/100ps
module wtc_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [wtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Watchdog
  input wire logic safety_fuse,
  input wire logic wdt_reset_req,
  input wire logic wdt_active
);
  logic [2:0] ce_cnt_r;
  logic flag_r;
  logic wr_wd;
  assign wr_wd = reg_wr && reg_addr == wtc_pkg::OFS_WDCTL;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Window mirror: nonzero while a write still sees change-enable set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_cnt_r <= 3'h0;
    end else if (wr_wd && reg_wdata[4]) begin
      ce_cnt_r <= 3'h4;
    end else if (ce_cnt_r != 3'h0) begin
      ce_cnt_r <= ce_cnt_r - 3'h1;
    end
  end
  // Reset flag mirror, in step with the design; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (wdt_reset_req) begin
      flag_r <= 1'b1;
    end else if (reg_wr && reg_addr == wtc_pkg::OFS_CAUSE && !reg_wdata[0]) begin
      flag_r <= 1'b0;
    end
  end
  ////////////////////////////////////////
  sequence s_ce;
    wr_wd && reg_wdata[4];
  endsequence
  sequence s_arm;
    wr_wd && reg_wdata[4] && reg_wdata[3];
  endsequence
  sequence s_drop;
    wr_wd && !reg_wdata[3] && !safety_fuse && !flag_r && !wdt_reset_req;
  endsequence
  sequence s_rd0;
    reg_rd && reg_addr == wtc_pkg::OFS_WDCTL;
  endsequence
  property p_lock;
    wr_wd && !reg_wdata[3] && ce_cnt_r == 3'h0 && wdt_active |=> wdt_active;
  endproperty
  property p_on;
    wr_wd && reg_wdata[3] |=> wdt_active;
  endproperty
  property p_off;
    s_arm ##[1:4] s_drop |=> !wdt_active;
  endproperty
  property p_lvl2;
    safety_fuse && wdt_active |=> wdt_active;
  endproperty
  property p_flag;
    flag_r |-> wdt_active;
  endproperty
  property p_rsvd;
    s_rd0 |=> reg_rdata[7:5] == 3'h0;
  endproperty
  property p_ce_seen;
    s_ce ##1 !reg_wr ##1 s_rd0 |=> reg_rdata[4];
  endproperty
  property p_ce_gone;
    reg_rd && reg_addr == wtc_pkg::OFS_WDCTL && ce_cnt_r == 3'h0 |=> !reg_rdata[4];
  endproperty
  property p_req;
    wdt_reset_req |-> $past(wdt_active) ##1 !wdt_reset_req;
  endproperty
  a_lock: assert property (p_lock) else $error("enable cleared without window");
  a_on: assert property (p_on) else $error("enable write ignored");
  a_off: assert property (p_off) else $error("timed disable ignored");
  a_lvl2: assert property (p_lvl2) else $error("level two disabled");
  a_flag: assert property (p_flag) else $error("flag set but disabled");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  a_ce_seen: assert property (p_ce_seen) else $error("change-enable missing");
  a_ce_gone: assert property (p_ce_gone) else $error("change-enable stuck");
  a_req: assert property (p_req) else $error("bad reset request");
endmodule

/* File: verif/wtc_cpu_model.sv */
`timescale 1ns/100ps
module wtc_cpu_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [wtc_pkg::ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core
  output logic watchdog_restart_instr
);
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    watchdog_restart_instr = 1'b0;
  end
  // Released lines show the inverse so stale data never looks live
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  task automatic restart();
    @(posedge clk);
    watchdog_restart_instr <= 1'b1;
    @(posedge clk);
    watchdog_restart_instr <= 1'b0;
    #1;
  endtask
  task automatic disable_wd(input logic [2:0] ps);
    wr(3'h4, 8'h00);
    wr(3'h0, {5'h03, ps});
    wr(3'h0, {5'h00, ps});
  endtask
  task automatic set_timeout(input logic [2:0] ps);
    restart();
    wr(3'h0, 8'h18);
    wr(3'h0, {5'h01, ps});
  endtask
endmodule

/* File: verif/watchdog_timed_control_tb_top.sv */
`timescale 1ns/100ps
module watchdog_timed_control_tb_top;
  logic clk;
  logic rst_n;
  logic scl_tick;
  logic safety_fuse;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic watchdog_restart_instr;
  logic wdt_reset_req;
  logic wdt_active;
  logic interval_tick;
  logic sense_tick;
  logic motion_sense_on;
  logic irq;
  int fails;
  int tests_run;
  int cyc = 0;
  int n;
  logic [7:0] d;
  // Rows: address, write data, read-back value
  logic [18:0] rows [6] = '{{3'h0, 8'hef, 8'h08}, {3'h1, 8'heb, 8'heb}, {3'h3, 8'hff, 8'h07},
    {3'h4, 8'h01, 8'h00}, {3'h2, 8'h07, 8'h00}, {3'h7, 8'hff, 8'h00}};
  wtc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_tick(scl_tick),
    .watchdog_restart_instr(watchdog_restart_instr), .safety_fuse(safety_fuse),
    .wdt_reset_req(wdt_reset_req), .wdt_active(wdt_active), .interval_tick(interval_tick),
    .sense_tick(sense_tick), .motion_sense_on(motion_sense_on), .irq(irq));
  wtc_cpu_model i_cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watchdog_restart_instr(watchdog_restart_instr));
  ////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    i_cpu.rd(a, d);
    chk(d, e);
  endtask
  // Cycles between two ticks; 2000 means none seen
  task automatic gap(input bit s);
    n = 0;
    while ((s ? sense_tick : interval_tick) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((s ? sense_tick : interval_tick) !== 1'b1 && n < 2000);
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    scl_tick = 1'b0;
    safety_fuse = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(i[2:0], 8'h00);
    for (int i = 0; i < 6; i++) begin
      i_cpu.wr(rows[i][18:16], rows[i][15:8]);
      rdc(rows[i][18:16], rows[i][7:0]);
    end
    i_cpu.wr(3'h0, 8'h00);
    rdc(3'h0, 8'h08);
    i_cpu.set_timeout(3'h5);
    // This read is taken at the fourth edge of the window, so change-enable still shows
    rdc(3'h0, 8'h1d);
    i_cpu.wr(3'h0, 8'h1d);
    rdc(3'h0, 8'h1d);
    repeat (4) @(posedge clk);
    rdc(3'h0, 8'h0d);
    i_cpu.wr(3'h0, 8'h05);
    chk(wdt_active, 1'b1);
    i_cpu.disable_wd(3'h0);
    chk(wdt_active, 1'b0);
    i_cpu.wr(3'h1, 8'h10);
    rdc(3'h1, 8'h10);
    repeat (4) @(posedge clk);
    rdc(3'h1, 8'h00);
    @(posedge clk);
    scl_tick <= 1'b1;
    i_cpu.wr(3'h1, 8'hc8);
    gap(1'b0);
    chk(n, 8);
    chk(irq, 1'b1);
    // First gap may start on a tick of the old selection; the second one is clean
    i_cpu.wr(3'h1, 8'hca);
    gap(1'b0);
    gap(1'b0);
    chk(n, 128);
    gap(1'b1);
    chk(n, 32);
    chk(motion_sense_on, 1'b1);
    i_cpu.wr(3'h1, 8'he0);
    chk(motion_sense_on, 1'b0);
    gap(1'b1);
    chk(n, 2000);
    i_cpu.wr(3'h3, 8'h00);
    chk(irq, 1'b0);
    @(posedge clk);
    scl_tick <= 1'b0;
    // Let the last tap and tick pulses drain, or a late event would beat the clear
    repeat (2) @(posedge clk);
    i_cpu.wr(3'h2, 8'h07);
    rdc(3'h2, 8'h00);
    i_cpu.wr(3'h3, 8'h07);
    chk(irq, 1'b0);
    // Watchdog run at timeout code 0 with one slow tick per clock
    @(posedge clk);
    scl_tick <= 1'b1;
    i_cpu.wr(3'h0, 8'h08);
    i_cpu.wr(3'h1, 8'h10);
    rdc(3'h1, 8'h00);
    repeat (5000) @(posedge clk);
    i_cpu.restart();
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n > 7168 && n <= 8196, 1'b1);
    rdc(3'h4, 8'h01);
    i_cpu.wr(3'h0, 8'h18);
    i_cpu.wr(3'h0, 8'h00);
    chk(wdt_active, 1'b1);
    i_cpu.disable_wd(3'h0);
    chk(wdt_active, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    safety_fuse <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(wdt_active, 1'b1);
    i_cpu.disable_wd(3'h0);
    chk(wdt_active, 1'b1);
    final_report();
  end
endmodule
bind wtc_top wtc_top_checker i_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .safety_fuse(safety_fuse), .wdt_reset_req(wdt_reset_req), .wdt_active(wdt_active));
